// *** acc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module acc_core_model (
	input  wire logic                   core_clk,
	input  wire logic                   arst_n,
	input  wire acc_pkg::acc_core_req_t core_req,
	input  wire logic [9:0]             level,
	input  wire logic [6:0]             lag,
	output logic                        core_done,
	output logic [9:0]                  core_code
);
	logic [6:0] left;
	logic [9:0] held;
	// Latch level and channel on start, answer after the lag
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			left <= 7'h0;
			held <= 10'h0;
			core_done <= 1'b0;
			core_code <= 10'h0;
		end else if (core_req.start) begin
			left <= lag;
			held <= level ^ {5'h0, core_req.channel};
			core_done <= 1'b0;
			core_code <= ~core_code;
		end else if (left != 7'h0) begin
			left <= left - 7'h1;
			core_code <= ~core_code; // Not valid yet
		end else begin
			core_done <= 1'b1;
			core_code <= held;
		end
	end
endmodule : acc_core_model
`default_nettype wire

// *** acc_pkg.sv ***
`default_nettype none
package acc_pkg;
	// Register byte offsets
	localparam logic [4:0] OFS_CMP_CS   = 5'h00;
	localparam logic [4:0] OFS_SPECIAL  = 5'h04;
	localparam logic [4:0] OFS_MUX_SEL  = 5'h08;
	localparam logic [4:0] OFS_CONV_CS  = 5'h0c;
	localparam logic [4:0] OFS_RES_LOW  = 5'h10;
	localparam logic [4:0] OFS_RES_HIGH = 5'h14;
	// Comparator control/status fields
	localparam int CMP_OUT_BIT   = 5;
	localparam int CMP_FLAG_BIT  = 4;
	localparam int CMP_IEN_BIT   = 3;
	localparam int CMP_ROUTE_BIT = 2;
	// Special function fields
	localparam int SPC_TRIG_LSB  = 5;
	localparam int SPC_MUXEN_BIT = 3;
	// Converter mux select fields
	localparam int MUX_REF_LSB   = 6;
	localparam int MUX_LADJ_BIT  = 5;
	// Converter control/status fields
	localparam int CNV_EN_BIT    = 7;
	localparam int CNV_START_BIT = 6;
	localparam int CNV_AUTO_BIT  = 5;
	localparam int CNV_FLAG_BIT  = 4;
	localparam int CNV_IEN_BIT   = 3;
	// Reset values
	localparam logic [7:0] RST_REG = 8'h00;
	// Conversion lengths in converter clock cycles
	localparam logic [4:0] CONV_NORMAL = 5'd13;
	localparam logic [4:0] CONV_FIRST  = 5'd25;
	// Trigger source codes
	localparam logic [2:0] TRIG_FREE = 3'h0;
	localparam logic [2:0] TRIG_CMP  = 3'h1;
	// Edge select decoding
	typedef enum logic [1:0] {
		EDGE_TOGGLE = 2'h0,
		EDGE_RSVD   = 2'h1,
		EDGE_FALL   = 2'h2,
		EDGE_RISE   = 2'h3
	} acc_edge_t;
	// Request to the analog core
	typedef struct packed {
		logic       start;
		logic [1:0] reference_select;
		logic [4:0] channel;
	} acc_core_req_t;
endpackage : acc_pkg
`default_nettype wire

// *** acc_top.sv ***
// Contract
// - comparator output bit passes a synchroniser
// - matching synchronised edge sets comparator flag
// - flag clears on vector or written one
// - irq requires flag, enable and global enable
// - capture route feeds comparator to timer
// - edge field: toggle, reserved, falling, rising
// - mux enable and converter off selects channel
// - converter works only while enabled
// - ten-bit result right or left aligned
// - low byte read locks result until high
// - done flag set even when result discarded
// - start bit reads one until conversion ends
// - channel change waits for running conversion
// - auto trigger edge resets prescaler, starts
// - trigger edges during conversion are ignored
// - trigger flags set without interrupt enables
// - done-flag source restarts after every conversion
// - 13 cycles, first 25; then flag, clear
// - prescaler held in reset while disabled
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module acc_top (
	input  wire logic                 core_clk,
	input  wire logic                 arst_n,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	input  wire logic                 cmp_raw,
	input  wire logic                 global_irq_enable,
	input  wire logic                 cmp_irq_ack,
	output logic                      cmp_irq,
	output logic                      capture_in,
	output logic                      neg_use_channel,
	output logic [2:0]                neg_channel,
	input  wire logic [5:0]           trig_src,
	output logic                      conv_irq,
	output acc_pkg::acc_core_req_t    core_req,
	input  wire logic                 core_done,
	input  wire logic [9:0]           core_code
);
	typedef enum {ST_IDLE, ST_WAIT, ST_RUN} acc_state_t;

	logic [7:0]  cmp_cs;
	logic [7:0]  special;
	logic [7:0]  mux_sel;
	logic [7:0]  conv_cs;
	logic [3:0]  cmp_ctl;
	logic [7:0]  conv_ctl;
	logic        next_conv_en;
	logic [9:0]  result;
	logic        locked;
	logic        cmp_s1, cmp_s2, cmp_s3;
	logic        cmp_event;
	logic        cmp_flag;
	logic        conv_flag;
	logic        dph_wr;
	logic [4:0]  dph_addr;
	logic        aph_take;
	logic        wr_now;
	logic [7:0]  wbyte;
	logic [31:0] next_rdata;
	logic [6:0]  presc;
	logic        tick;
	acc_state_t  state;
	logic [4:0]  run_cnt;
	logic        first_pend;
	logic        conv_en;
	logic        complete;
	logic        sw_start;
	logic        trig_sig, trig_prev, trig_edge;
	logic        auto_start;
	logic        busy;

	////////////////////////////////////////////////////////////////
	// Bus slave
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign aph_take = hsel & htrans[1] & hready;
	assign wr_now = dph_wr;
	assign wbyte = hwdata[7:0];

	// Data phase capture
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			dph_wr <= 1'b0;
			dph_addr <= 5'h00;
		end else begin
			dph_wr <= aph_take & hwrite & (haddr[31:5] == 27'h0); // Upper addresses ignored
			dph_addr <= haddr[4:0];
		end
	end

	// Read data chosen at address phase
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (haddr[31:5] == 27'h0) begin
			unique case (haddr[4:0])
				acc_pkg::OFS_CMP_CS: next_rdata[7:0] = cmp_cs;
				acc_pkg::OFS_SPECIAL: next_rdata[7:0] = special;
				acc_pkg::OFS_MUX_SEL: next_rdata[7:0] = mux_sel;
				acc_pkg::OFS_CONV_CS: next_rdata[7:0] = conv_cs;
				acc_pkg::OFS_RES_LOW: next_rdata[7:0] = mux_sel[acc_pkg::MUX_LADJ_BIT] ?
					{result[1:0], 6'h00} : result[7:0];
				acc_pkg::OFS_RES_HIGH: next_rdata[7:0] = mux_sel[acc_pkg::MUX_LADJ_BIT] ?
					result[9:2] : {6'h00, result[9:8]};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Registered read data
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			hrdata <= 32'h0000_0000;
		else if (aph_take && !hwrite)
			hrdata <= next_rdata;
	end

	////////////////////////////////////////////////////////////////
	// Comparator synchroniser and edge detect
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmp_s1 <= 1'b0;
			cmp_s2 <= 1'b0;
			cmp_s3 <= 1'b0;
		end else begin
			cmp_s1 <= cmp_raw;
			cmp_s2 <= cmp_s1;
			cmp_s3 <= cmp_s2;
		end
	end

	// Edge mode decode
	always_comb begin
		unique case (acc_pkg::acc_edge_t'(cmp_cs[1:0]))
			acc_pkg::EDGE_TOGGLE: cmp_event = cmp_s2 ^ cmp_s3;
			acc_pkg::EDGE_RSVD: cmp_event = 1'b0;
			acc_pkg::EDGE_FALL: cmp_event = cmp_s3 & ~cmp_s2;
			acc_pkg::EDGE_RISE: cmp_event = cmp_s2 & ~cmp_s3;
		endcase
	end

	// Comparator control bits
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			cmp_ctl <= acc_pkg::RST_REG[3:0];
		else if (wr_now && dph_addr == acc_pkg::OFS_CMP_CS)
			cmp_ctl <= wbyte[3:0];
	end

	// Comparator flag, set beats clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			cmp_flag <= 1'b0;
		else if (cmp_event)
			cmp_flag <= 1'b1;
		else if (cmp_irq_ack ||
			(wr_now && dph_addr == acc_pkg::OFS_CMP_CS && wbyte[acc_pkg::CMP_FLAG_BIT]))
			cmp_flag <= 1'b0;
	end

	// Status byte: output bit 5, flag bit 4, control bits below
	assign cmp_cs = {2'b00, cmp_s2, cmp_flag, cmp_ctl};
	assign cmp_irq = cmp_flag & cmp_cs[acc_pkg::CMP_IEN_BIT] & global_irq_enable;
	assign capture_in = cmp_cs[acc_pkg::CMP_ROUTE_BIT] & cmp_s2;
	assign neg_use_channel = special[acc_pkg::SPC_MUXEN_BIT] & ~conv_en;
	assign neg_channel = mux_sel[2:0];

	////////////////////////////////////////////////////////////////
	// Plain control registers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			special <= acc_pkg::RST_REG;
			mux_sel <= acc_pkg::RST_REG;
			conv_ctl <= acc_pkg::RST_REG;
		end else if (wr_now) begin
			if (dph_addr == acc_pkg::OFS_SPECIAL)
				special <= wbyte;
			if (dph_addr == acc_pkg::OFS_MUX_SEL)
				mux_sel <= wbyte;
			if (dph_addr == acc_pkg::OFS_CONV_CS) begin
				conv_ctl <= {wbyte[7], 1'b0, wbyte[5], 1'b0, wbyte[3:0]};
			end
		end
	end

	assign conv_en = conv_ctl[acc_pkg::CNV_EN_BIT];
	assign busy = (state != ST_IDLE);
	assign conv_cs = {conv_ctl[7], busy, conv_ctl[5], conv_flag, conv_ctl[3:0]};
	// Enable as it stands after this edge, so enable and start may share a write
	assign next_conv_en = (wr_now && dph_addr == acc_pkg::OFS_CONV_CS) ? wbyte[acc_pkg::CNV_EN_BIT] : conv_en;
	assign conv_irq = conv_flag & conv_cs[acc_pkg::CNV_IEN_BIT] & global_irq_enable;
	assign sw_start = wr_now && dph_addr == acc_pkg::OFS_CONV_CS && wbyte[acc_pkg::CNV_START_BIT];

	////////////////////////////////////////////////////////////////
	// Trigger edge detect
	always_comb begin
		unique case (special[7:5])
			acc_pkg::TRIG_FREE: trig_sig = 1'b0;
			acc_pkg::TRIG_CMP: trig_sig = cmp_flag;
			default: trig_sig = trig_src[3'(special[7:5] - 3'h2)];
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			trig_prev <= 1'b0;
		else
			trig_prev <= trig_sig;
	end

	assign trig_edge = trig_sig & ~trig_prev;
	assign auto_start = conv_en & conv_cs[acc_pkg::CNV_AUTO_BIT] & trig_edge & ~busy;

	// Prescaler and converter clock tick
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			presc <= 7'h00;
		else if (!conv_en || auto_start)
			presc <= 7'h00;
		else
			presc <= presc + 7'h01;
	end

	assign tick = conv_en && ((presc | ~7'((8'h02 << conv_cs[2:0]) - 8'h01)) == 7'h7f) &&
		!(conv_cs[2:0] == 3'h7 && presc != 7'h7f);

	////////////////////////////////////////////////////////////////
	// Conversion sequencer
	assign complete = (state == ST_RUN) && tick &&
		(run_cnt >= (first_pend ? acc_pkg::CONV_FIRST : acc_pkg::CONV_NORMAL)) && core_done;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
			run_cnt <= 5'h00;
		end else if (!next_conv_en) begin
			state <= ST_IDLE;
			run_cnt <= 5'h00;
		end else begin
			unique case (state)
				ST_IDLE:
					if (sw_start || auto_start)
						state <= ST_WAIT;
				ST_WAIT:
					if (tick) begin
						state <= ST_RUN;
						run_cnt <= 5'h01;
					end
				ST_RUN:
					if (complete) begin
						// Free running restarts at once
						if (conv_cs[acc_pkg::CNV_AUTO_BIT] && special[7:5] == acc_pkg::TRIG_FREE)
							state <= ST_WAIT;
						else
							state <= ST_IDLE;
						run_cnt <= 5'h00;
					end else if (tick && run_cnt != 5'h1f)
						run_cnt <= run_cnt + 5'h01;
			endcase
		end
	end

	// First conversion after enable is long
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			first_pend <= 1'b0;
		else if (!conv_en)
			first_pend <= 1'b1;
		else if (complete)
			first_pend <= 1'b0;
	end

	// Done flag, set beats clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			conv_flag <= 1'b0;
		else if (complete)
			conv_flag <= 1'b1;
		else if (wr_now && dph_addr == acc_pkg::OFS_CONV_CS && wbyte[acc_pkg::CNV_FLAG_BIT])
			conv_flag <= 1'b0;
	end

	// Result store and read lock
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			result <= 10'h000;
			locked <= 1'b0;
		end else begin
			if (complete && !locked)
				result <= core_code;
			if (aph_take && !hwrite && haddr == {27'h0, acc_pkg::OFS_RES_LOW})
				locked <= 1'b1;
			else if (aph_take && !hwrite && haddr == {27'h0, acc_pkg::OFS_RES_HIGH})
				locked <= 1'b0;
		end
	end

	// Core selects track only while enabled and not running
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			core_req <= '0;
		else begin
			core_req.start <= next_conv_en && (state == ST_WAIT) && tick;
			if (conv_en && state != ST_RUN) begin
				core_req.reference_select <= mux_sel[7:6];
				core_req.channel <= mux_sel[4:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	chk_sync_lag: assert property (@(posedge core_clk) disable iff (!arst_n)
		##2 cmp_cs[acc_pkg::CMP_OUT_BIT] == $past(cmp_raw, 2)) else $error("sync lag wrong");
	chk_flag_rise: assert property (@(posedge core_clk) disable iff (!arst_n)
		(cmp_cs[1:0] == 2'h3 && cmp_s2 && !cmp_s3) |=> cmp_flag) else $error("rise flag missed");
	chk_flag_ack: assert property (@(posedge core_clk) disable iff (!arst_n)
		(cmp_irq_ack && !cmp_event) |=> !cmp_flag) else $error("flag not cleared");
	chk_irq_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
		cmp_irq |-> (cmp_flag && cmp_cs[3] && global_irq_enable)) else $error("irq ungated");
	chk_capture_off: assert property (@(posedge core_clk) disable iff (!arst_n)
		!cmp_cs[2] |-> !capture_in) else $error("capture leaks");
	chk_neg_mux: assert property (@(posedge core_clk) disable iff (!arst_n)
		conv_en |-> !neg_use_channel) else $error("mux while enabled");
	chk_lock_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
		(locked && !aph_take) |=> $stable(result)) else $error("locked result moved");
	chk_done_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
		complete |=> conv_flag) else $error("done flag missed");
	chk_busy_bit: assert property (@(posedge core_clk) disable iff (!arst_n)
		(sw_start && next_conv_en) |=> conv_cs[6] [*2]) else $error("start bit dropped");
	chk_presc_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
		!conv_en |=> presc == 7'h00) else $error("prescaler ran");
endmodule : acc_top
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                   core_clk = 1'b0;
	logic                   arst_n = 1'b0;
	logic                   hsel = 1'b0;
	logic                   hwrite = 1'b0;
	logic [1:0]             htrans = 2'h0;
	logic [31:0]            haddr = 32'h0;
	logic [31:0]            hwdata = 32'h0;
	logic                   raw = 1'b0;
	logic                   gie = 1'b1;
	logic                   ack = 1'b0;
	logic [5:0]             trig = 6'h0;
	logic [9:0]             lvl = 10'h0;
	logic [6:0]             lag = 7'h1;
	logic [31:0]            hrdata, rd;
	logic                   hreadyout, hresp, cmp_irq, cap, use_ch, conv_irq, done;
	logic [2:0]             neg_ch, ch;
	logic [9:0]             code, ecode, old;
	logic [7:0]             mux;
	acc_pkg::acc_core_req_t req;
	int                     mismatches = 0;
	int                     n_compared = 0;
	int                     n_start = 0;
	int                     ns;
	always #25 core_clk = ~core_clk;
	// Count start strobes to the core
	always @(posedge core_clk) if (req.start === 1'b1) n_start <= n_start + 1;
	acc_top dut_u (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .cmp_raw(raw), .global_irq_enable(gie), .cmp_irq_ack(ack),
		.cmp_irq(cmp_irq), .capture_in(cap), .neg_use_channel(use_ch), .neg_channel(neg_ch),
		.trig_src(trig), .conv_irq(conv_irq), .core_req(req), .core_done(done), .core_code(code));
	acc_core_model core_u (.core_clk(core_clk), .arst_n(arst_n), .core_req(req), .level(lvl),
		.lag(lag), .core_done(done), .core_code(code));
	////////////////////////////////////////////////////////////////
	task automatic close_out;
		if (mismatches == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Bounded wait for hready
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			mismatches++;
			close_out();
		end
	endtask : wait_rdy
	// One single word transfer, data phase after address phase
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {27'h0, a};
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		wait_rdy();
		rd = hrdata;
	endtask : bus
	// Result byte as software should see it
	function automatic logic [31:0] res(input logic [9:0] c, input logic la, input logic hi);
		logic [15:0] w;
		w = la ? {c, 6'h0} : {6'h0, c};
		return {24'h0, hi ? w[15:8] : w[7:0]};
	endfunction : res
	// Run one conversion to its done flag
	task automatic conv(input logic [7:0] ctl, input int n, input logic rdres);
		int cyc;
		bus(1'b1, acc_pkg::OFS_MUX_SEL, mux);
		bus(1'b1, acc_pkg::OFS_CONV_CS, ctl);
		bus(1'b0, acc_pkg::OFS_CONV_CS, 8'h0);
		chk(rd[acc_pkg::CNV_START_BIT], 1'b1);
		bus(1'b1, acc_pkg::OFS_MUX_SEL, mux ^ 8'h01);
		chk({req.reference_select, req.channel}, {mux[7:6], mux[4:0]});
		cyc = 4;
		do begin
			bus(1'b0, acc_pkg::OFS_CONV_CS, 8'h0);
			cyc += 2;
		end while (rd[acc_pkg::CNV_FLAG_BIT] !== 1'b1 && cyc < 400);
		if (cyc >= 400) begin
			mismatches++;
			close_out();
		end
		chk(cyc >= 2 * n - 2 && cyc <= 2 * n + 8 || n == 0, 1'b1);
		chk({rd[acc_pkg::CNV_START_BIT], conv_irq}, 2'h1);
		ecode = lvl ^ {5'h0, mux[4:0]};
		if (rdres) begin
			bus(1'b0, acc_pkg::OFS_RES_LOW, 8'h0);
			chk(rd, res(ecode, mux[5], 1'b0));
			bus(1'b0, acc_pkg::OFS_RES_HIGH, 8'h0);
			chk(rd, res(ecode, mux[5], 1'b1));
		end
		bus(1'b1, acc_pkg::OFS_CONV_CS, ctl & 8'hbf | 8'h10);
	endtask : conv
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(44));
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		// Reset values, last address unmapped
		for (int a = 0; a < 7; a++) begin
			bus(1'b0, 5'(a * 4), 8'h0);
			chk(rd, 32'h0);
			chk({hreadyout, hresp}, 2'h2);
		end
		// Comparator edge modes, reserved code sets no flag
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, acc_pkg::OFS_CMP_CS, 8'h14 | 8'(m));
			bus(1'b1, acc_pkg::OFS_CMP_CS, 8'h0c | 8'(m));
			raw <= 1'b1;
			@(posedge core_clk);
			#1 chk(cap, 1'b0);
			@(posedge core_clk);
			#1 chk(cap, 1'b1);
			repeat (2) @(posedge core_clk);
			chk(cmp_irq, m == 0 || m == 3);
			ack <= 1'b1;
			@(posedge core_clk);
			ack <= 1'b0;
			@(posedge core_clk);
			chk(cmp_irq, 1'b0);
			raw <= 1'b0;
			repeat (4) @(posedge core_clk);
			chk(cmp_irq, m == 0 || m == 2);
			gie <= 1'b0;
			@(posedge core_clk);
			chk(cmp_irq, 1'b0);
			gie <= 1'b1;
			bus(1'b1, acc_pkg::OFS_CMP_CS, 8'h18 | 8'(m));
			bus(1'b0, acc_pkg::OFS_CMP_CS, 8'h0);
			chk(rd, 32'(8'h08 | 8'(m)));
		end
		// Negative input from a channel while converter is off
		ch = 3'($urandom);
		bus(1'b1, acc_pkg::OFS_SPECIAL, 8'h08);
		bus(1'b1, acc_pkg::OFS_MUX_SEL, {5'h18, ch});
		@(posedge core_clk);
		chk({use_ch, neg_ch}, {1'b1, ch});
		chk(req, 8'h0);
		// First and normal conversions, both alignments, slow core last
		for (int k = 0; k < 4; k++) begin
			mux = {2'(k), k[0], 2'h0, ch};
			lvl <= 10'($urandom);
			lag <= k == 3 ? 7'd90 : 7'd1;
			conv(8'hc8, k == 0 ? 25 : k == 3 ? 0 : 13, 1'b1);
		end
		lag <= 7'd1;
		chk(use_ch, 1'b0);
		// Low byte read locks out the next result
		bus(1'b0, acc_pkg::OFS_RES_LOW, 8'h0);
		old = ecode;
		lvl <= ~lvl;
		conv(8'hc8, 13, 1'b0);
		bus(1'b0, acc_pkg::OFS_RES_HIGH, 8'h0);
		chk(rd, res(old, mux[5], 1'b1));
		conv(8'hc8, 13, 1'b1);
		// Auto trigger on source code 2, extra edge while busy
		bus(1'b1, acc_pkg::OFS_SPECIAL, 8'h40);
		bus(1'b1, acc_pkg::OFS_CONV_CS, 8'ha0);
		ns = n_start;
		trig <= {5'($urandom), 1'b1};
		repeat (6) @(posedge core_clk);
		bus(1'b0, acc_pkg::OFS_CONV_CS, 8'h0);
		chk(rd[acc_pkg::CNV_START_BIT], 1'b1);
		trig[0] <= 1'b0;
		repeat (3) @(posedge core_clk);
		trig[0] <= 1'b1;
		repeat (80) @(posedge core_clk);
		chk(n_start - ns, 32'h1);
		// Free running restarts with the flag left set
		bus(1'b1, acc_pkg::OFS_SPECIAL, 8'h00);
		ns = n_start;
		bus(1'b1, acc_pkg::OFS_CONV_CS, 8'he0);
		repeat (100) @(posedge core_clk);
		chk(n_start - ns >= 3, 1'b1);
		bus(1'b1, acc_pkg::OFS_CONV_CS, 8'h00);
		ns = n_start;
		repeat (60) @(posedge core_clk);
		chk(n_start - ns, 32'h0);
		close_out();
	end
endmodule : testbench
`default_nettype wire
